// *** rtl/uart_pkg.sv ***
// package for the asynchronous serial port, modes 1 to 3
// assumes one system clock; timer 1 overflow generated inside the main module
package uart_pkg;
   localparam logic [1:0] MODE_SYNC  = 2'h0;
   localparam logic [1:0] MODE_ONE   = 2'h1;
   localparam logic [1:0] MODE_TWO   = 2'h2;
   localparam logic [1:0] MODE_THREE = 2'h3;
   localparam int         TIMER_SPAN      = 256;
   localparam logic [3:0] PRESCALE_SLOW   = 4'hB; // divide by 12, count 11..0
   localparam logic [3:0] PRESCALE_FAST   = 4'h3; // divide by 4, count 3..0
   localparam logic [7:0] TIMER_MAX       = 8'hFF;
   localparam logic [5:0] SYS_DIV_NORMAL  = 6'h3F; // mode 2 bit divide by 64
   localparam logic [5:0] SYS_DIV_DOUBLE  = 6'h1F; // mode 2 bit divide by 32
   localparam logic [4:0] OVF_DIV_NORMAL  = 5'h1F; // mode 1/3 divide by 32
   localparam logic [4:0] OVF_DIV_DOUBLE  = 5'h0F; // mode 1/3 divide by 16
   localparam logic [1:0] OVS_SHIFT_SYS   = 2'h2;  // 64 sys clocks / 16 samples = 4
   localparam logic [1:0] OVS_SHIFT_SYS_D = 2'h1;  // 32 / 16 = 2
   localparam logic [3:0] SAMPLE_A        = 4'h7;
   localparam logic [3:0] SAMPLE_B        = 4'h8;
   localparam logic [3:0] SAMPLE_C        = 4'h9;
   localparam logic [3:0] SAMPLE_LAST     = 4'hF;
   localparam logic [3:0] BITS_SHORT      = 4'h9;  // start + 8 data + stop, index of stop
   localparam logic [3:0] BITS_LONG       = 4'hA;  // start + 8 + ninth + stop
   localparam logic [7:0] DATA_RESET      = 8'h00;
endpackage

// *** rtl/uart_rx_sampler.sv ***
// 16x oversample counter and three-sample majority vote for one receiver
// assumes sample strobe and synchronised rx level on the same clock
module uart_rx_sampler (
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst_b,
   // control
   input  wire logic i_sample_tick,
   input  wire logic i_restart,
   input  wire logic i_rx_level,
   // results
   output logic      o_bit_valid,
   output logic      o_bit_value,
   output logic      o_bit_end
);
   logic [3:0] phase_reg;
   logic [2:0] votes_reg;

   // sample phase counter, restarted on each start edge
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         phase_reg <= 4'h0;
      end else if (i_restart) begin
         phase_reg <= 4'h0;
      end else if (i_sample_tick) begin
         phase_reg <= phase_reg + 4'h1;
      end
   end

   // collect the three middle samples
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         votes_reg <= 3'h7;
      end else if (i_sample_tick && (phase_reg == uart_pkg::SAMPLE_A ||
                   phase_reg == uart_pkg::SAMPLE_B || phase_reg == uart_pkg::SAMPLE_C)) begin
         votes_reg <= {votes_reg[1:0], i_rx_level};
      end
   end

   // majority decision after the third sample, end-of-bit strobe
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_bit_valid <= 1'b0;
         o_bit_value <= 1'b1;
         o_bit_end   <= 1'b0;
      end else begin
         o_bit_valid <= i_sample_tick && !i_restart && phase_reg == uart_pkg::SAMPLE_C;
         o_bit_end   <= i_sample_tick && !i_restart && phase_reg == uart_pkg::SAMPLE_LAST;
         if (i_sample_tick && phase_reg == uart_pkg::SAMPLE_C) begin
            o_bit_value <= (votes_reg[1] & votes_reg[0]) | (votes_reg[1] & i_rx_level) |
                           (votes_reg[0] & i_rx_level);
         end
      end
   end
endmodule

// *** rtl/uart_async_port.sv ***
// asynchronous serial port, modes 1 to 3, with timer 1 baud source
// assumes control bits come from the processor on i_core_clk; rx pin is asynchronous
module uart_async_port (
   // clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_b,
   // timer 1 baud source
   input  wire logic       i_timer_prescale_select,
   input  wire logic [7:0] i_timer_reload_value,
   // port configuration
   input  wire logic       i_mode_select_high,
   input  wire logic       i_mode_select_low,
   input  wire logic       i_baud_double,
   input  wire logic       i_multiproc_filter,
   input  wire logic       i_rx_enable,
   input  wire logic       i_tx_ninth_bit,
   // buffer write and flag clears
   input  wire logic       i_buffer_write,
   input  wire logic [7:0] i_buffer_wdata,
   input  wire logic       i_tx_done_clear,
   input  wire logic       i_rx_done_clear,
   // pins
   input  wire logic       i_rx_pin,
   output logic            o_tx_pin,
   // status
   output logic [7:0]      o_rx_buffer,
   output logic            o_rx_ninth_bit,
   output logic            o_rx_done,
   output logic            o_tx_done,
   output logic            o_tx_busy,
   output logic            o_timer_overflow
);
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_SHIFT} rx_state_t;

   // decoded mode and baud chain
   logic [1:0] mode;
   logic       async_mode;
   logic       long_frame;
   logic       timer_baud;
   logic [3:0] prescale_reg;
   logic [7:0] timer_reg;
   logic       timer_tick;
   logic       ovf_div_reg;
   logic [1:0] ovs_div_reg;
   logic       ovs_tick;
   // transmit path
   logic       tx_bit_tick;
   logic [3:0] tx_phase_reg;
   logic [3:0] tx_count_reg;
   logic [9:0] tx_shift_reg;
   // receive path
   logic       rx_sync1_reg;
   logic       rx_sync2_reg;
   logic       rx_prev_reg;
   rx_state_t  rx_state_reg;
   logic [3:0] rx_count_reg;
   logic [8:0] rx_shift_reg;
   logic       rx_restart;
   logic       bit_valid;
   logic       bit_value;
   logic       rx_accept;
   logic       rx_last_bit;
   logic       ninth_seen;

   // mode decode and frame length
   // mode 0 is not served here, so it blocks both directions
   assign mode       = {i_mode_select_high, i_mode_select_low};
   assign async_mode = (mode != uart_pkg::MODE_SYNC);
   assign long_frame = mode[1];
   assign timer_baud = (mode == uart_pkg::MODE_ONE) || (mode == uart_pkg::MODE_THREE);

   // timer 1 prescaler, divide by 12 or 4
   // a new prescale choice takes effect at the next reload of this count
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prescale_reg <= 4'h0;
      end else if (prescale_reg == 4'h0) begin
         prescale_reg <= i_timer_prescale_select ? uart_pkg::PRESCALE_FAST
                                                 : uart_pkg::PRESCALE_SLOW;
      end else begin
         prescale_reg <= prescale_reg - 4'h1;
      end
   end
   assign timer_tick = (prescale_reg == 4'h0);

   // timer 1 as 8-bit auto-reload counter
   // the overflow pulse follows the rollover tick by one clock
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         timer_reg        <= 8'h00;
         o_timer_overflow <= 1'b0;
      end else begin
         o_timer_overflow <= timer_tick && timer_reg == uart_pkg::TIMER_MAX;
         if (timer_tick) begin
            timer_reg <= (timer_reg == uart_pkg::TIMER_MAX) ? i_timer_reload_value
                                                            : timer_reg + 8'h01;
         end
      end
   end

   // overflow divider: 16 samples per bit come from every overflow (doubled) or every
   // second overflow, so the bit is 16 or 32 overflows long
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ovf_div_reg <= 1'b0;
      end else if (o_timer_overflow) begin
         ovf_div_reg <= ~ovf_div_reg;
      end
   end

   // system clock divider for mode 2, sample rate clock/4 or clock/2
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ovs_div_reg <= 2'h0;
      end else begin
         ovs_div_reg <= ovs_div_reg + 2'h1;
      end
   end

   // oversample tick per mode
   // timer modes take every overflow when doubled, every second one otherwise
   always_comb begin
      if (timer_baud) begin
         ovs_tick = o_timer_overflow && (i_baud_double || ovf_div_reg);
      end else if (i_baud_double) begin
         ovs_tick = ovs_div_reg[0];
      end else begin
         ovs_tick = (ovs_div_reg == 2'h3);
      end
   end

   // transmit bit timing: sixteen oversample ticks per bit
   // the phase runs free, so a write waits up to one bit for its start bit
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tx_phase_reg <= 4'h0;
      end else if (ovs_tick) begin
         tx_phase_reg <= tx_phase_reg + 4'h1;
      end
   end
   assign tx_bit_tick = ovs_tick && (tx_phase_reg == uart_pkg::SAMPLE_LAST);

   // transmit shifter: start, data lsb first, optional ninth, stop
   // the ninth slot holds a one in mode 1, where it goes out as the stop bit
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_tx_pin     <= 1'b1;
         o_tx_busy    <= 1'b0;
         tx_count_reg <= 4'h0;
         tx_shift_reg <= 10'h3FF;
      end else if (!o_tx_busy) begin
         o_tx_pin <= 1'b1;
         if (i_buffer_write && async_mode) begin
            o_tx_busy    <= 1'b1;
            tx_count_reg <= 4'h0;
            tx_shift_reg <= {1'b1, long_frame ? i_tx_ninth_bit : 1'b1,
                             i_buffer_wdata};
         end
      end else if (tx_bit_tick) begin
         if (tx_count_reg == 4'h0) begin
            o_tx_pin <= 1'b0; // start bit
         end else begin
            o_tx_pin     <= tx_shift_reg[0];
            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
         end
         tx_count_reg <= tx_count_reg + 4'h1;
         // the frame ends one bit after the stop bit went out
         if (tx_count_reg == (long_frame ? uart_pkg::BITS_LONG + 4'h1
                                         : uart_pkg::BITS_SHORT + 4'h1)) begin
            o_tx_pin  <= 1'b1; // stop bit time over, release
            o_tx_busy <= 1'b0;
         end
      end
   end

   // transmit-done: set when the stop bit goes out; set wins over clear
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_tx_done <= 1'b0;
      end else if (o_tx_busy && tx_bit_tick &&
                   tx_count_reg == (long_frame ? uart_pkg::BITS_LONG : uart_pkg::BITS_SHORT)) begin
         o_tx_done <= 1'b1;
      end else if (i_tx_done_clear) begin
         o_tx_done <= 1'b0;
      end
   end

   // rx pin synchroniser and edge history
   // only the second flop feeds logic; the third gives the falling edge
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rx_sync1_reg <= 1'b1;
         rx_sync2_reg <= 1'b1;
         rx_prev_reg  <= 1'b1;
      end else begin
         rx_sync1_reg <= i_rx_pin;
         rx_sync2_reg <= rx_sync1_reg;
         rx_prev_reg  <= rx_sync2_reg;
      end
   end
   assign rx_restart = (rx_state_reg == RX_IDLE) && i_rx_enable && async_mode &&
                       rx_prev_reg && !rx_sync2_reg;

   // majority sampler
   uart_rx_sampler u_sampler (
      .i_core_clk    (i_core_clk),
      .i_rst_b       (i_rst_b),
      .i_sample_tick (ovs_tick),
      .i_restart     (rx_restart),
      .i_rx_level    (rx_sync2_reg),
      .o_bit_valid   (bit_valid),
      .o_bit_value   (bit_value),
      .o_bit_end     ()
   );

   // last bit is stop; data index counts data and ninth bits
   // bit_value holds the stop majority in the cycle the stop bit is decided
   assign rx_last_bit = (rx_count_reg == (long_frame ? uart_pkg::BITS_LONG - 4'h1
                                                     : uart_pkg::BITS_SHORT - 4'h1));
   assign ninth_seen  = long_frame ? rx_shift_reg[8] : 1'b1;
   assign rx_accept   = !o_rx_done && (!i_multiproc_filter ||
                        (bit_value && ninth_seen));

   // receive state machine
   // a start majority of one drops back to idle to wait for a new edge
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rx_state_reg <= RX_IDLE;
         rx_count_reg <= 4'h0;
         rx_shift_reg <= 9'h000;
      end else begin
         unique case (rx_state_reg)
            RX_IDLE: begin
               if (rx_restart) begin
                  rx_state_reg <= RX_START;
               end
            end
            RX_START: begin
               if (bit_valid) begin
                  rx_count_reg <= 4'h0;
                  rx_state_reg <= bit_value ? RX_IDLE : RX_SHIFT;
               end
            end
            RX_SHIFT: begin
               if (bit_valid) begin
                  if (rx_last_bit) begin
                     rx_state_reg <= RX_IDLE;
                  end else begin
                     rx_count_reg <= rx_count_reg + 4'h1;
                     // lsb first: shift in from the top of the used field
                     if (long_frame) begin
                        rx_shift_reg <= {bit_value, rx_shift_reg[8:1]};
                     end else begin
                        rx_shift_reg <= {1'b0, bit_value, rx_shift_reg[7:1]};
                     end
                  end
               end
            end
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end

   // receive result: buffer, ninth bit and done flag; set wins over clear
   // a refused frame leaves buffer, ninth bit and flag as they were
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rx_buffer    <= uart_pkg::DATA_RESET;
         o_rx_ninth_bit <= 1'b0;
         o_rx_done      <= 1'b0;
      end else if (rx_state_reg == RX_SHIFT && bit_valid && rx_last_bit && rx_accept) begin
         o_rx_buffer    <= rx_shift_reg[7:0];
         o_rx_ninth_bit <= long_frame ? rx_shift_reg[8] : bit_value;
         o_rx_done      <= 1'b1;
      end else if (i_rx_done_clear) begin
         o_rx_done <= 1'b0;
      end
   end
endmodule

// *** verification/uart_port_chk.sv ***
// concurrent checks on the async serial port, bound to its top module
// assumes one clock; timer checks hold only with prescale by 4 and reload at 8'hFF
module uart_port_chk (
   // clock and reset
   input wire logic       i_core_clk,
   input wire logic       i_rst_b,
   // watched inputs
   input wire logic       i_timer_prescale_select,
   input wire logic [7:0] i_timer_reload_value,
   input wire logic       i_mode_select_high,
   input wire logic       i_mode_select_low,
   input wire logic       i_multiproc_filter,
   input wire logic       i_buffer_write,
   input wire logic       i_tx_done_clear,
   input wire logic       i_rx_done_clear,
   // watched outputs
   input wire logic       o_tx_pin,
   input wire logic [7:0] o_rx_buffer,
   input wire logic       o_rx_ninth_bit,
   input wire logic       o_rx_done,
   input wire logic       o_tx_done,
   input wire logic       o_tx_busy,
   input wire logic       o_timer_overflow
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   logic fast_top;
   // timer set to roll over every four clocks
   assign fast_top = i_timer_prescale_select && (i_timer_reload_value == 8'hFF);
   // transmit side and timer
   a_tx_idle_high: assert property (!o_tx_busy |-> o_tx_pin)
      else $error("tx pin low while idle");
   a_tx_start_soon: assert property ($rose(o_tx_busy) && fast_top |-> ##[1:140] !o_tx_pin)
      else $error("no start bit after write");
   a_tx_done_stop: assert property ($rose(o_tx_done) |-> o_tx_pin && o_tx_busy)
      else $error("tx done not on stop bit");
   a_sync_write_ignored: assert property (i_buffer_write && !i_mode_select_high
      && !i_mode_select_low && !o_tx_busy |=> !o_tx_busy)
      else $error("write taken in mode 0");
   a_timer_period: assert property (o_timer_overflow && fast_top
      |=> !o_timer_overflow [*3] ##1 o_timer_overflow)
      else $error("timer overflow period wrong");
   // flags and receive side
   a_tx_done_held: assert property (o_tx_done && !i_tx_done_clear |=> o_tx_done)
      else $error("tx done dropped by hardware");
   a_rx_done_held: assert property (o_rx_done && !i_rx_done_clear |=> o_rx_done)
      else $error("rx done dropped by hardware");
   a_rx_frozen: assert property (o_rx_done && !i_rx_done_clear
      |=> $stable(o_rx_buffer) && $stable(o_rx_ninth_bit))
      else $error("rx buffer changed while done set");
   a_filter_ninth: assert property ($rose(o_rx_done) && i_multiproc_filter
      && i_mode_select_high |-> o_rx_ninth_bit)
      else $error("filtered frame with ninth bit zero");
   a_mode1_stop: assert property ($rose(o_rx_done) && i_multiproc_filter
      && !i_mode_select_high && i_mode_select_low |-> o_rx_ninth_bit)
      else $error("filtered mode 1 frame with bad stop");
endmodule

bind uart_async_port uart_port_chk chk_u (
   .i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
   .i_timer_prescale_select(i_timer_prescale_select),
   .i_timer_reload_value(i_timer_reload_value),
   .i_mode_select_high(i_mode_select_high), .i_mode_select_low(i_mode_select_low),
   .i_multiproc_filter(i_multiproc_filter), .i_buffer_write(i_buffer_write),
   .i_tx_done_clear(i_tx_done_clear), .i_rx_done_clear(i_rx_done_clear),
   .o_tx_pin(o_tx_pin), .o_rx_buffer(o_rx_buffer), .o_rx_ninth_bit(o_rx_ninth_bit),
   .o_rx_done(o_rx_done), .o_tx_done(o_tx_done), .o_tx_busy(o_tx_busy),
   .o_timer_overflow(o_timer_overflow)
);

// *** verification/remote_node.sv ***
// remote serial node: sends frames onto the port's rx pin, samples its tx pin
// assumes the caller runs at the falling clock edge and knows the bit period in clocks
module remote_node (
   // clock
   input  wire logic i_clk,
   // lines
   input  wire logic i_line,
   output logic      o_line
);
   timeunit 1ns;
   timeprecision 1ns;
   // line idles at the stop level
   initial o_line = 1'b1;

   // frame word goes out bit 0 first, nb bits long
   task automatic send(input logic [10:0] bits, input int nb, input int per);
      for (int i = 0; i < nb; i++) begin
         o_line = bits[i];
         repeat (per) @(negedge i_clk);
      end
      o_line = 1'b1;
   endtask

   // short low pulse that must not be taken as a start bit
   task automatic glitch(input int len);
      o_line = 1'b0;
      repeat (len) @(negedge i_clk);
      o_line = 1'b1;
   endtask

   // waits for the start bit under a bound, then samples each bit centre
   task automatic recv(input int nb, input int per, output logic [10:0] bits, output logic ok);
      int n;
      bits = '1;
      ok = 1'b0;
      for (n = 0; n < 2000 && i_line === 1'b1; n++) @(negedge i_clk);
      if (i_line === 1'b0) begin
         ok = 1'b1;
         repeat (per / 2) @(negedge i_clk);
         for (int i = 0; i < nb; i++) begin
            bits[i] = i_line;
            repeat (per) @(negedge i_clk);
         end
      end
   endtask
endmodule

// *** verification/tb.sv ***
// self-checking bench for the async serial port, modes 1 to 3
// assumes timer 1 prescale by 4 with reload 8'hFF: one overflow every 4 clocks
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
   $display("wrong value %s expected %0h seen %0h", nm, (ex), (got)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic       core_clk, rst_b, presc, mh, ml, dbl, filt, ren, tx9, wr, txc, rxc;
   logic [7:0] reload, wdata, rx_buf;
   logic       tx_pin, rx_pin, rx9, rx_done, tx_done, tx_busy, ovf;
   int         num_errors = 0;
   int         check_count = 0;

   uart_async_port dut_u (.i_core_clk(core_clk), .i_rst_b(rst_b),
      .i_timer_prescale_select(presc), .i_timer_reload_value(reload),
      .i_mode_select_high(mh), .i_mode_select_low(ml), .i_baud_double(dbl),
      .i_multiproc_filter(filt), .i_rx_enable(ren), .i_tx_ninth_bit(tx9),
      .i_buffer_write(wr), .i_buffer_wdata(wdata), .i_tx_done_clear(txc),
      .i_rx_done_clear(rxc), .i_rx_pin(rx_pin), .o_tx_pin(tx_pin), .o_rx_buffer(rx_buf),
      .o_rx_ninth_bit(rx9), .o_rx_done(rx_done), .o_tx_done(tx_done), .o_tx_busy(tx_busy),
      .o_timer_overflow(ovf));
   remote_node node_u (.i_clk(core_clk), .i_line(tx_pin), .o_line(rx_pin));

   // 10 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // expected frame word, bit 0 sent first
   function automatic logic [10:0] frame_of(int nb, logic [7:0] d, logic n9, logic stp);
      return (nb == 10) ? {1'b1, stp, d, 1'b0} : {stp, n9, d, 1'b0};
   endfunction

   task automatic set_cfg(input logic [1:0] m, input logic d, input logic f);
      @(negedge core_clk);
      {mh, ml} = m;
      dbl = d;
      filt = f;
   endtask

   task automatic clear_flags;
      @(negedge core_clk);
      txc = 1'b1;
      rxc = 1'b1;
      @(negedge core_clk);
      txc = 1'b0;
      rxc = 1'b0;
   endtask

   task automatic send_byte(input logic [7:0] d, input logic n9);
      @(negedge core_clk);
      wdata = d;
      tx9 = n9;
      wr = 1'b1;
      @(negedge core_clk);
      wr = 1'b0;
   endtask

   // overflow spacing once a new timer setting has settled
   task automatic test_timer(input logic p, input logic [7:0] rl, input int per);
      int n;
      int gap;
      @(negedge core_clk);
      presc = p;
      reload = rl;
      gap = 0;
      for (int k = 0; k < 3; k++) begin
         @(negedge core_clk);
         for (n = 1; n < 4000 && ovf !== 1'b1; n++) @(negedge core_clk);
         gap = n;
      end
      `CHK("overflow period", per, gap)
      if (gap == 4000) end_sim;
      $display("test timer prescale %0d reload %0h finished", p, rl);
   endtask

   task automatic test_tx(input logic [1:0] m, input logic d, input int per, input int nb,
                          input logic [7:0] data, input logic n9);
      logic [10:0] got;
      logic        ok;
      int          n;
      set_cfg(m, d, 1'b0);
      send_byte(data, n9);
      @(negedge core_clk);
      `CHK("tx busy", 1'b1, tx_busy)
      node_u.recv(nb, per, got, ok);
      `CHK("tx start", 1'b1, ok)
      `CHK("tx frame", frame_of(nb, data, n9, 1'b1), got)
      `CHK("tx done", 1'b1, tx_done)
      for (n = 0; n < 3000 && tx_busy !== 1'b0; n++) @(negedge core_clk);
      if (n == 3000) begin
         num_errors++;
         end_sim;
      end
      `CHK("tx done kept", 1'b1, tx_done)
      `CHK("tx idle", 1'b1, tx_pin)
      clear_flags;
      $display("test tx mode %0d double %0d finished", m, d);
   endtask

   task automatic test_rx(input logic [1:0] m, input logic d, input logic f, input int per,
      input int nb, input logic [7:0] data, input logic n9, input logic stp, input logic acc);
      logic [7:0] old_buf;
      logic       old9;
      logic       old_done;
      set_cfg(m, d, f);
      old_buf = rx_buf;
      old9 = rx9;
      old_done = rx_done;
      node_u.send(frame_of(nb, data, n9, stp), nb, per);
      repeat (per) @(negedge core_clk);
      `CHK("rx done", acc | old_done, rx_done)
      `CHK("rx data", acc ? data : old_buf, rx_buf)
      `CHK("rx ninth", acc ? ((nb == 10) ? stp : n9) : old9, rx9)
      $display("test rx mode %0d data %0h finished", m, data);
   endtask

   task automatic test_false_start;
      clear_flags;
      set_cfg(2'h2, 1'b0, 1'b0);
      node_u.glitch(6);
      repeat (64 * 12) @(negedge core_clk);
      `CHK("rx done after glitch", 1'b0, rx_done)
      ren = 1'b0;
      node_u.send(frame_of(11, 8'h99, 1'b0, 1'b1), 11, 64);
      repeat (64) @(negedge core_clk);
      `CHK("rx done disabled", 1'b0, rx_done)
      ren = 1'b1;
      test_rx(2'h2, 1'b0, 1'b0, 64, 11, 8'h5A, 1'b1, 1'b1, 1'b1);
      set_cfg(2'h0, 1'b0, 1'b0);
      send_byte(8'h33, 1'b0);
      @(negedge core_clk);
      `CHK("mode 0 write", 1'b0, tx_busy)
      $display("test false start and refusals finished");
   endtask

   // main sequence
   initial begin
      {rst_b, mh, ml, dbl, filt, tx9, wr, txc, rxc} = '0;
      {presc, ren} = 2'h3;
      reload = 8'hFF;
      wdata = 8'h00;
      repeat (2) @(negedge core_clk);
      `CHK("tx pin in reset", 1'b1, tx_pin)
      `CHK("flags in reset", 2'h0, {tx_done, rx_done})
      rst_b = 1'b1;
      test_timer(1'b0, 8'hFE, 24);
      test_timer(1'b1, 8'hFF, 4);
      test_tx(2'h1, 1'b0, 128, 10, 8'hA5, 1'b0);
      test_tx(2'h1, 1'b1, 64, 10, 8'h1E, 1'b0);
      test_tx(2'h2, 1'b0, 64, 11, 8'hC6, 1'b1);
      test_tx(2'h2, 1'b1, 32, 11, 8'h3B, 1'b0);
      test_tx(2'h3, 1'b1, 64, 11, 8'h81, 1'b1);
      test_rx(2'h1, 1'b1, 1'b0, 64, 10, 8'h3C, 1'b0, 1'b1, 1'b1);
      test_rx(2'h1, 1'b1, 1'b0, 64, 10, 8'h55, 1'b0, 1'b1, 1'b0);
      clear_flags;
      test_rx(2'h1, 1'b1, 1'b1, 64, 10, 8'h66, 1'b0, 1'b0, 1'b0);
      test_rx(2'h2, 1'b0, 1'b1, 64, 11, 8'h24, 1'b0, 1'b1, 1'b0);
      test_rx(2'h3, 1'b1, 1'b1, 64, 11, 8'hC3, 1'b1, 1'b1, 1'b1);
      clear_flags;
      test_rx(2'h2, 1'b1, 1'b0, 32, 11, 8'h7E, 1'b0, 1'b1, 1'b1);
      test_false_start;
      end_sim;
   end
endmodule
